// ==== imp_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

// Picks the winning request: high level first, then lowest source index.
module imp_arbiter #(
  parameter int unsigned N = 18
) (
  input  wire logic [N-1:0] i_req,
  input  wire logic [N-1:0] i_high,
  output logic              o_valid,
  output logic              o_high,
  output logic [4:0]        o_idx
);

  // Scan from the top down so the lowest index is the last to overwrite.
  always_comb begin
    logic [N-1:0] hi_req;
    hi_req  = i_req & i_high;
    o_valid = |i_req;
    o_high  = |hi_req;
    o_idx   = 5'h00;
    for (int k = N - 1; k >= 0; k--) begin
      if (o_high ? hi_req[k] : i_req[k]) begin
        o_idx = 5'(k);
      end
    end
  end

endmodule : imp_arbiter

`default_nettype wire

// ==== imp_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Core side: takes a shown request after a chosen wait, then returns after a service time.
module imp_core_model
  import imp_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire imp_grant_t i_grant,
  input  wire logic       i_take,
  input  wire logic [3:0] i_delay,
  input  wire logic [3:0] i_svc_len,
  output logic            o_vec_ack,
  output logic            o_svc_return,
  output imp_grant_t      o_taken_grant
);
  int   wait_c;
  int   lo_left;
  int   hi_left;
  logic ack_n;
  logic ret_n;

  initial begin
    o_vec_ack = 1'b0;
    o_svc_return = 1'b0;
    o_taken_grant = '0;
  end

  // Ack is raised just after an edge and seen at the next one with the same grant.
  always @(posedge i_core_clk) begin
    #2;
    ack_n = 1'b0;
    ret_n = 1'b0;
    if (!i_nrst) begin
      wait_c = 0;
      lo_left = 0;
      hi_left = 0;
    end else if (i_take && i_grant.valid && wait_c >= i_delay) begin
      ack_n = 1'b1;
      wait_c = 0;
      o_taken_grant = i_grant;
      if (i_grant.high) hi_left = i_svc_len;
      else lo_left = i_svc_len;
    end else begin
      if (i_grant.valid) wait_c++;
      if (hi_left > 0) begin
        hi_left--;
        ret_n = (hi_left == 0);
      end else if (lo_left > 0) begin
        lo_left--;
        ret_n = (lo_left == 0);
      end
    end
    o_vec_ack = ack_n;
    o_svc_return = ret_n;
  end
endmodule : imp_core_model

`default_nettype wire

// ==== imp_ctl.sv ====
// Operation
// - Global gate low blocks every source.
// - Timer mask bits gate timer overflow requests.
// - UART mask gates receive and transmit requests.
// - Pin mask bits gate external pin requests.
// - Main level bits set six sources' priority.
// - First extended masks gate comparator edges.
// - First extended masks gate ADC window, SPI.
// - Second extended masks gate soft interrupts.
// - Second extended masks gate crystal, ADC done.
// - First extended level bits set priorities.
// - Second extended level bits set priorities.
// - Unused bits read zero, ignore writes.
// - Reserved bit six always reads zero.
// - High preempts low; high never preempted.
// - Higher level first, ties by order.
// - Requests sampled and decoded every clock-enabled cycle.
// - Soft trigger raises request; software clears.
`timescale 1ns/1ps
`default_nettype none
`include "imp_ctl_map.svh"

module imp_ctl
  import imp_pkg::*;
#(
  parameter int unsigned NUM_SRC = IMP_NUM_SRC
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_clk_en,
  input  wire imp_sfr_req_t i_sfr,
  input  wire imp_flags_t   i_flags,
  input  wire logic         i_ext_irq_pin0_n,
  input  wire logic         i_ext_irq_pin1_n,
  input  wire logic         i_vec_ack,
  input  wire logic         i_svc_return,
  output logic [7:0]        o_sfr_rdata,
  output logic              o_sfr_rvalid,
  output imp_grant_t        o_grant,
  output imp_svc_t          o_svc_state
);

  // Register file.
  logic [7:0] enable_main_q, enable_main_d;
  logic [7:0] level_main_q,  level_main_d;
  logic [7:0] enable_one_q,  enable_one_d;
  logic [7:0] enable_two_q,  enable_two_d;
  logic [7:0] level_one_q,   level_one_d;
  logic [7:0] level_two_q,   level_two_d;
  logic [7:0] soft_trig_q,   soft_trig_d;
  logic [7:0] rdata_q,       rdata_d;
  logic       rvalid_q,      rvalid_d;

  // Pin synchronisers.
  logic [1:0] pin_meta_q, pin_meta_d;
  logic [1:0] pin_sync_q, pin_sync_d;

  // Service nesting and presented request.
  imp_svc_t   svc_q, svc_d;
  imp_grant_t grant_q, grant_d;

  // Per-source views.
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] src_mask;
  logic [NUM_SRC-1:0] src_level;
  logic [NUM_SRC-1:0] gated_req;
  logic [NUM_SRC-1:0] eligible_req;
  logic               arb_valid;
  logic               arb_high;
  logic [4:0]         arb_idx;

  // Register writes and reads. Each write is masked so unused and
  // reserved bits stay zero whatever software puts on the bus.
  always_comb begin
    enable_main_d = enable_main_q;
    level_main_d  = level_main_q;
    enable_one_d  = enable_one_q;
    enable_two_d  = enable_two_q;
    level_one_d   = level_one_q;
    level_two_d   = level_two_q;
    soft_trig_d   = soft_trig_q;
    rdata_d       = rdata_q;
    rvalid_d      = i_sfr.rd;
    if (i_sfr.wr) begin
      unique case (i_sfr.addr)
        `IMP_ADDR_ENABLE_MAIN: enable_main_d = i_sfr.wdata & `IMP_WMASK_ENABLE_MAIN;
        `IMP_ADDR_LEVEL_MAIN:  level_main_d  = i_sfr.wdata & `IMP_WMASK_LEVEL_MAIN;
        `IMP_ADDR_ENABLE_ONE:  enable_one_d  = i_sfr.wdata & `IMP_WMASK_EXT_ONE;
        `IMP_ADDR_ENABLE_TWO:  enable_two_d  = i_sfr.wdata & `IMP_WMASK_EXT_TWO;
        `IMP_ADDR_LEVEL_ONE:   level_one_d   = i_sfr.wdata & `IMP_WMASK_EXT_ONE;
        `IMP_ADDR_LEVEL_TWO:   level_two_d   = i_sfr.wdata & `IMP_WMASK_EXT_TWO;
        `IMP_ADDR_SOFT_TRIG:   soft_trig_d   = i_sfr.wdata & `IMP_WMASK_SOFT_TRIG;
        default: ;
      endcase
    end
    if (i_sfr.rd) begin
      // Unmapped addresses answer zero.
      unique case (i_sfr.addr)
        `IMP_ADDR_ENABLE_MAIN: rdata_d = enable_main_q;
        `IMP_ADDR_LEVEL_MAIN:  rdata_d = level_main_q;
        `IMP_ADDR_ENABLE_ONE:  rdata_d = enable_one_q;
        `IMP_ADDR_ENABLE_TWO:  rdata_d = enable_two_q;
        `IMP_ADDR_LEVEL_ONE:   rdata_d = level_one_q;
        `IMP_ADDR_LEVEL_TWO:   rdata_d = level_two_q;
        `IMP_ADDR_SOFT_TRIG:   rdata_d = soft_trig_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  // Registers hold while the clock enable is low.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      enable_main_q <= `IMP_REG_RESET;
      level_main_q  <= `IMP_REG_RESET;
      enable_one_q  <= `IMP_REG_RESET;
      enable_two_q  <= `IMP_REG_RESET;
      level_one_q   <= `IMP_REG_RESET;
      level_two_q   <= `IMP_REG_RESET;
      soft_trig_q   <= `IMP_REG_RESET;
      rdata_q       <= 8'h00;
      rvalid_q      <= 1'b0;
    end else if (i_clk_en) begin
      enable_main_q <= enable_main_d;
      level_main_q  <= level_main_d;
      enable_one_q  <= enable_one_d;
      enable_two_q  <= enable_two_d;
      level_one_q   <= level_one_d;
      level_two_q   <= level_two_d;
      soft_trig_q   <= soft_trig_d;
      rdata_q       <= rdata_d;
      rvalid_q      <= rvalid_d;
    end
  end

  // The pins come from outside the clock domain; the first stage feeds
  // only the second, and the active-low level is inverted after that.
  always_comb begin
    pin_meta_d = {i_ext_irq_pin1_n, i_ext_irq_pin0_n};
    pin_sync_d = pin_meta_q;
  end

  // Synchroniser stages idle high, matching released pins.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
    end else if (i_clk_en) begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
    end
  end

  // Raw pending requests by source index.
  always_comb begin
    raw_req                   = '0;
    raw_req[IMP_SRC_PIN0]     = !pin_sync_q[0];
    raw_req[IMP_SRC_TIMER0]   = i_flags.timer0_overflow_flag;
    raw_req[IMP_SRC_PIN1]     = !pin_sync_q[1];
    raw_req[IMP_SRC_TIMER1]   = i_flags.timer1_overflow_flag;
    raw_req[IMP_SRC_UART]     = i_flags.uart_rx_done | i_flags.uart_tx_done;
    raw_req[IMP_SRC_TIMER2]   = i_flags.timer2_overflow_flag;
    raw_req[IMP_SRC_SPI]      = i_flags.spi_irq;
    raw_req[IMP_SRC_ADC_WIN]  = i_flags.adc_window;
    raw_req[IMP_SRC_CMP0_F]   = i_flags.cmp0_fall;
    raw_req[IMP_SRC_CMP0_R]   = i_flags.cmp0_rise;
    raw_req[IMP_SRC_CMP1_F]   = i_flags.cmp1_fall;
    raw_req[IMP_SRC_CMP1_R]   = i_flags.cmp1_rise;
    raw_req[IMP_SRC_ADC_DONE] = i_flags.adc_done;
    raw_req[IMP_SRC_CRYSTAL]  = i_flags.crystal_valid_flag;
    for (int k = 0; k < 4; k++) begin
      raw_req[int'(IMP_SRC_SOFT0) + k] = soft_trig_q[`IMP_BIT_SOFT0_TRIG + k];
    end
  end

  // Mask bit of each source.
  always_comb begin
    src_mask = '0;
    src_mask[IMP_SRC_TIMER2]   = enable_main_q[`IMP_BIT_TIMER2];
    src_mask[IMP_SRC_TIMER1]   = enable_main_q[`IMP_BIT_TIMER1];
    src_mask[IMP_SRC_TIMER0]   = enable_main_q[`IMP_BIT_TIMER0];
    src_mask[IMP_SRC_UART]     = enable_main_q[`IMP_BIT_UART];
    src_mask[IMP_SRC_PIN1]     = enable_main_q[`IMP_BIT_PIN1];
    src_mask[IMP_SRC_PIN0]     = enable_main_q[`IMP_BIT_PIN0];
    src_mask[IMP_SRC_CMP1_R]   = enable_one_q[`IMP_BIT_CMP1_RISE];
    src_mask[IMP_SRC_CMP1_F]   = enable_one_q[`IMP_BIT_CMP1_FALL];
    src_mask[IMP_SRC_CMP0_R]   = enable_one_q[`IMP_BIT_CMP0_RISE];
    src_mask[IMP_SRC_CMP0_F]   = enable_one_q[`IMP_BIT_CMP0_FALL];
    src_mask[IMP_SRC_ADC_WIN]  = enable_one_q[`IMP_BIT_ADC_WIN];
    src_mask[IMP_SRC_SPI]      = enable_one_q[`IMP_BIT_SPI];
    src_mask[IMP_SRC_CRYSTAL]  = enable_two_q[`IMP_BIT_CRYSTAL];
    src_mask[IMP_SRC_ADC_DONE] = enable_two_q[`IMP_BIT_ADC_DONE];
    for (int k = 0; k < 4; k++) begin
      src_mask[int'(IMP_SRC_SOFT0) + k] = enable_two_q[`IMP_BIT_SOFT0_EN + k];
    end
  end

  // Priority level of each source; one means high.
  always_comb begin
    src_level = '0;
    src_level[IMP_SRC_TIMER2]   = level_main_q[`IMP_BIT_TIMER2];
    src_level[IMP_SRC_UART]     = level_main_q[`IMP_BIT_UART];
    src_level[IMP_SRC_TIMER1]   = level_main_q[`IMP_BIT_TIMER1];
    src_level[IMP_SRC_PIN1]     = level_main_q[`IMP_BIT_PIN1];
    src_level[IMP_SRC_TIMER0]   = level_main_q[`IMP_BIT_TIMER0];
    src_level[IMP_SRC_PIN0]     = level_main_q[`IMP_BIT_PIN0];
    src_level[IMP_SRC_CMP1_R]   = level_one_q[`IMP_BIT_CMP1_RISE];
    src_level[IMP_SRC_CMP1_F]   = level_one_q[`IMP_BIT_CMP1_FALL];
    src_level[IMP_SRC_CMP0_R]   = level_one_q[`IMP_BIT_CMP0_RISE];
    src_level[IMP_SRC_CMP0_F]   = level_one_q[`IMP_BIT_CMP0_FALL];
    src_level[IMP_SRC_ADC_WIN]  = level_one_q[`IMP_BIT_ADC_WIN];
    src_level[IMP_SRC_SPI]      = level_one_q[`IMP_BIT_SPI];
    src_level[IMP_SRC_CRYSTAL]  = level_two_q[`IMP_BIT_CRYSTAL];
    src_level[IMP_SRC_ADC_DONE] = level_two_q[`IMP_BIT_ADC_DONE];
    for (int k = 0; k < 4; k++) begin
      src_level[int'(IMP_SRC_SOFT0) + k] = level_two_q[`IMP_BIT_SOFT0_EN + k];
    end
  end

  // Gating by mask, global gate and current service depth. A running
  // high routine blocks everything, a running low one admits only high.
  always_comb begin
    gated_req = raw_req & src_mask & {NUM_SRC{enable_main_q[`IMP_BIT_GATE]}};
    unique case (svc_q)
      IMP_SVC_IDLE: eligible_req = gated_req;
      IMP_SVC_LOW:  eligible_req = gated_req & src_level;
      default:      eligible_req = '0;
    endcase
  end

  imp_arbiter #(
    .N (NUM_SRC)
  ) u_arbiter (
    .i_req   (eligible_req),
    .i_high  (src_level),
    .o_valid (arb_valid),
    .o_high  (arb_high),
    .o_idx   (arb_idx)
  );

  // Service depth follows the core's acknowledge and return strobes.
  // An acknowledge always refers to the request presented this cycle.
  always_comb begin
    grant_d.valid = arb_valid;
    grant_d.high  = arb_high;
    grant_d.id    = imp_src_t'(arb_idx);
    svc_d         = svc_q;
    unique case (svc_q)
      IMP_SVC_IDLE: begin
        if (i_vec_ack && grant_q.valid) begin
          svc_d = grant_q.high ? IMP_SVC_HIGH : IMP_SVC_LOW;
        end
      end
      IMP_SVC_LOW: begin
        if (i_vec_ack && grant_q.valid && grant_q.high) begin
          svc_d = IMP_SVC_NEST;
        end else if (i_svc_return) begin
          svc_d = IMP_SVC_IDLE;
        end
      end
      IMP_SVC_HIGH: begin
        if (i_svc_return) begin
          svc_d = IMP_SVC_IDLE;
        end
      end
      IMP_SVC_NEST: begin
        if (i_svc_return) begin
          svc_d = IMP_SVC_LOW;
        end
      end
      default: svc_d = IMP_SVC_IDLE;
    endcase
    // Drop the presented request the cycle after it was taken, so the
    // core never sees a stale grant while the depth updates.
    if (i_vec_ack) begin
      grant_d.valid = 1'b0;
    end
  end

  // Service state and presented request registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      svc_q   <= IMP_SVC_IDLE;
      grant_q <= '{valid: 1'b0, high: 1'b0, id: IMP_SRC_PIN0};
    end else if (i_clk_en) begin
      svc_q   <= svc_d;
      grant_q <= grant_d;
    end
  end

  // Outputs are taken straight from registers.
  assign o_sfr_rdata  = rdata_q;
  assign o_sfr_rvalid = rvalid_q;
  assign o_grant      = grant_q;
  assign o_svc_state  = svc_q;

endmodule : imp_ctl

`default_nettype wire

// ==== imp_ctl_map.svh ====
`ifndef IMP_CTL_MAP_SVH
`define IMP_CTL_MAP_SVH

// Register addresses on the special-function register bus.
`define IMP_ADDR_ENABLE_MAIN 8'ha8
`define IMP_ADDR_LEVEL_MAIN  8'hb8
`define IMP_ADDR_ENABLE_ONE  8'he6
`define IMP_ADDR_ENABLE_TWO  8'he7
`define IMP_ADDR_LEVEL_ONE   8'hf6
`define IMP_ADDR_LEVEL_TWO   8'hf7
`define IMP_ADDR_SOFT_TRIG   8'had

// Reset value shared by every mapped register of the block.
`define IMP_REG_RESET 8'h00

// Writable bits of each register; all others read zero.
`define IMP_WMASK_ENABLE_MAIN 8'hbf
`define IMP_WMASK_LEVEL_MAIN  8'h3f
`define IMP_WMASK_EXT_ONE     8'hf5
`define IMP_WMASK_EXT_TWO     8'hbe
`define IMP_WMASK_SOFT_TRIG   8'hf0

// Main enable and main level field positions.
`define IMP_BIT_GATE   7
`define IMP_BIT_TIMER2 5
`define IMP_BIT_UART   4
`define IMP_BIT_TIMER1 3
`define IMP_BIT_PIN1   2
`define IMP_BIT_TIMER0 1
`define IMP_BIT_PIN0   0

// First extended enable and level field positions.
`define IMP_BIT_CMP1_RISE 7
`define IMP_BIT_CMP1_FALL 6
`define IMP_BIT_CMP0_RISE 5
`define IMP_BIT_CMP0_FALL 4
`define IMP_BIT_ADC_WIN   2
`define IMP_BIT_SPI       0

// Second extended enable and level field positions.
`define IMP_BIT_CRYSTAL  7
`define IMP_BIT_SOFT0_EN 2
`define IMP_BIT_ADC_DONE 1

// Soft trigger register: trigger 0 sits at this bit, trigger 3 three above.
`define IMP_BIT_SOFT0_TRIG 4

`endif

// ==== imp_ctl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches gating, service nesting and register reads at the controller's ports.
module imp_ctl_monitor
  import imp_pkg::*;
#(
  parameter int unsigned NUM_SRC = IMP_NUM_SRC
) (
  input wire logic         i_core_clk,
  input wire logic         i_nrst,
  input wire logic         i_clk_en,
  input wire imp_sfr_req_t i_sfr,
  input wire logic         i_vec_ack,
  input wire logic         i_svc_return,
  input wire logic [7:0]   o_sfr_rdata,
  input wire logic         o_sfr_rvalid,
  input wire imp_grant_t   o_grant,
  input wire imp_svc_t     o_svc_state
);
  logic       gate_d;
  logic       gate_q;
  logic [7:0] addr_d;
  logic [7:0] addr_q;
  logic [7:0] rmask;

  // Shadow of the gate bit and of the last read address, updated like the registers.
  always_comb begin
    gate_d = gate_q;
    addr_d = addr_q;
    if (i_clk_en && i_sfr.wr && i_sfr.addr == 8'ha8) begin
      gate_d = i_sfr.wdata[7];
    end
    if (i_clk_en && i_sfr.rd) begin
      addr_d = i_sfr.addr;
    end
  end

  // Shadow state clears with the block; its next values already honour the clock enable.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      gate_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      gate_q <= gate_d;
      addr_q <= addr_d;
    end
  end

  // Bits that may read as one; an unmapped address reads all zero.
  always_comb begin
    case (addr_q)
      8'ha8:        rmask = 8'hbf;
      8'hb8:        rmask = 8'h3f;
      8'he6, 8'hf6: rmask = 8'hf5;
      8'he7, 8'hf7: rmask = 8'hbe;
      8'had:        rmask = 8'hf0;
      default:      rmask = 8'h00;
    endcase
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_gate_blocks_all: assert property (o_grant.valid |-> $past(gate_q))
    else $error("grant shown while the gate was closed");
  a_unused_zero: assert property (o_sfr_rvalid |-> (o_sfr_rdata & ~rmask) == 8'h00)
    else $error("unused register bit read as one");
  a_reserved_six: assert property (o_sfr_rvalid && (addr_q == 8'he7 || addr_q == 8'hf7)
    |-> !o_sfr_rdata[6]) else $error("reserved bit six read as one");
  a_read_answer: assert property (i_clk_en && i_sfr.rd |=> o_sfr_rvalid)
    else $error("read without answer");
  a_ack_gap: assert property (i_vec_ack && o_grant.valid |=> !o_grant.valid)
    else $error("grant still valid after acknowledge");
  a_low_entry: assert property (i_vec_ack && o_grant.valid && !o_grant.high
    && o_svc_state == IMP_SVC_IDLE |=> o_svc_state == IMP_SVC_LOW)
    else $error("low request did not start low service");
  a_high_preempts: assert property (i_vec_ack && o_grant.valid && o_grant.high
    && o_svc_state == IMP_SVC_LOW |=> o_svc_state == IMP_SVC_NEST)
    else $error("high request did not nest over low service");
  a_high_kept: assert property (o_svc_state inside {IMP_SVC_HIGH, IMP_SVC_NEST}
    && $past(o_svc_state) inside {IMP_SVC_HIGH, IMP_SVC_NEST} |-> !o_grant.valid)
    else $error("grant shown during high service");
  a_low_only_high: assert property (o_svc_state == IMP_SVC_LOW
    && $past(o_svc_state) == IMP_SVC_LOW && o_grant.valid |-> o_grant.high)
    else $error("low grant shown during low service");
  a_return_pops: assert property (o_svc_state == IMP_SVC_NEST && i_svc_return
    && !i_vec_ack |=> o_svc_state == IMP_SVC_LOW) else $error("return did not pop nesting");

  c_nested: cover property (o_svc_state == IMP_SVC_NEST);
  c_high_grant: cover property (o_grant.valid && o_grant.high);
  c_read: cover property (o_sfr_rvalid);
endmodule : imp_ctl_monitor

bind imp_ctl imp_ctl_monitor #(.NUM_SRC(NUM_SRC)) u_mon (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_sfr(i_sfr),
  .i_vec_ack(i_vec_ack), .i_svc_return(i_svc_return), .o_sfr_rdata(o_sfr_rdata),
  .o_sfr_rvalid(o_sfr_rvalid), .o_grant(o_grant), .o_svc_state(o_svc_state));

`default_nettype wire

// ==== imp_ctl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench
  import imp_pkg::*;
;
  localparam int EN_B [18] = '{0, 1, 2, 3, 4, 5, 0, 2, 4, 5, 6, 7, 1, 2, 3, 4, 5, 7};
  // Flag bit per source; minus one and two are the pins, minus three the soft triggers.
  localparam int TRG [18] = '{-1, 12, -2, 11, 9, 10, 7, 6, 4, 3, 2, 1, 5, -3, -3, -3, -3, 0};
  localparam logic [7:0] AD [8] = '{8'ha8, 8'hb8, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'had, 8'h55};
  localparam logic [7:0] WM [8] = '{8'hbf, 8'h3f, 8'hf5, 8'hbe, 8'hf5, 8'hbe, 8'hf0, 8'h00};

  logic         i_core_clk;
  logic         i_nrst;
  imp_sfr_req_t sfr;
  imp_flags_t   flags;
  logic         pin0_n;
  logic         pin1_n;
  logic         ack;
  logic         ret;
  logic         take;
  logic         ce;
  logic         rvalid;
  logic         lvl;
  logic [3:0]   dly;
  logic [7:0]   rdata;
  logic [7:0]   d;
  logic [7:0]   en_a;
  logic [7:0]   bitv;
  imp_grant_t   grant;
  imp_grant_t   taken_g;
  imp_svc_t     svc;
  int           miscompares;
  int           checks;
  logic [7:0]   rd_q[$];
  logic [5:0]   tk_q[$];

  imp_ctl DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clk_en(ce), .i_sfr(sfr),
    .i_flags(flags), .i_ext_irq_pin0_n(pin0_n), .i_ext_irq_pin1_n(pin1_n), .i_vec_ack(ack),
    .i_svc_return(ret), .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid), .o_grant(grant),
    .o_svc_state(svc));
  imp_core_model u_core (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_grant(grant),
    .i_take(take), .i_delay(dly), .i_svc_len(4'ha), .o_vec_ack(ack), .o_svc_return(ret),
    .o_taken_grant(taken_g));

  // Free-running core clock, 25 ns period.
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : cyc

  // A register access lasts one cycle, then the bus rests for one.
  task automatic access(input logic r, input logic [7:0] a, input logic [7:0] v);
    sfr = '{rd: r, wr: !r, addr: a, wdata: v};
    cyc(1);
    sfr = '0;
    cyc(1);
  endtask : access

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    access(1'b0, a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    access(1'b1, a, 8'h00);
  endtask : rd

  task automatic trig(input int s, input logic v);
    if (TRG[s] >= 0) flags[TRG[s]] = v;
    else if (TRG[s] == -1) pin0_n = !v;
    else if (TRG[s] == -2) pin1_n = !v;
    else wr(8'had, v ? 8'(8'h10 << (s - 13)) : 8'h00);
  endtask : trig

  task automatic drain(input int left);
    int n;
    n = 0;
    while (tk_q.size() > left && n < 80) begin
      cyc(1);
      n++;
    end
    check("pending takes", 8'(tk_q.size()), 8'(left));
  endtask : drain

  task automatic settle();
    int n;
    n = 0;
    while (svc !== IMP_SVC_IDLE && n < 60) begin
      cyc(1);
      n++;
    end
    check("service state", {4'h0, svc}, 8'h01);
  endtask : settle

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Outputs are settled one step after the edge; each result meets its oldest note.
  always @(posedge i_core_clk) begin
    #1;
    if (rvalid === 1'b1) check("read data", rdata, rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx);
    if (ack === 1'b1) check("taken request", {2'b00, taken_g.high, taken_g.id},
      tk_q.size() > 0 ? {2'b00, tk_q.pop_front()} : 8'hxx);
  end

  // Watchdog: the whole run needs well under a tenth of this span.
  initial begin
    #(25 * 20000);
    miscompares++;
    wrap_up();
  end

  // Main sequence of scenarios; the per-source and preemption ones end by waiting for the design to go idle.
  initial begin
    sfr = '0;
    flags = '0;
    pin0_n = 1'b1;
    pin1_n = 1'b1;
    take = 1'b0;
    ce = 1'b1;
    dly = 4'h0;
    miscompares = 0;
    checks = 0;
    i_nrst = 1'b0;
    cyc(8);
    i_nrst = 1'b1;
    void'($urandom(40));
    // Reset values, then all ones, random and zero written and read back.
    for (int i = 0; i < 8; i++) rd(AD[i], 8'h00);
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 8; i++) begin
        d = (p == 0) ? 8'hff : ((p == 1) ? 8'($urandom) : 8'h00);
        if (AD[i] == 8'he7 || AD[i] == 8'hf7) d[6] = 1'b0;
        wr(AD[i], d);
        rd(AD[i], d & WM[i]);
      end
    end
    // A write offered while the clock enable is low must not land.
    ce = 1'b0;
    sfr = '{rd: 1'b0, wr: 1'b1, addr: 8'hb8, wdata: 8'h3f};
    cyc(2);
    sfr = '0;
    ce = 1'b1;
    rd(8'hb8, 8'h00);
    // Each source alone: blocked while the gate is shut, taken once it opens.
    take = 1'b1;
    for (int s = 0; s < 18; s++) begin
      lvl = 1'($urandom);
      dly = 4'($urandom % 4);
      en_a = (s < 6) ? 8'ha8 : ((s < 12) ? 8'he6 : 8'he7);
      bitv = 8'(8'h01 << EN_B[s]);
      wr(8'he6, 8'h00);
      wr(8'he7, 8'h00);
      wr(8'ha8, en_a == 8'ha8 ? bitv : 8'h00);
      if (en_a != 8'ha8) wr(en_a, bitv);
      wr(en_a + 8'h10, lvl ? bitv : 8'h00);
      trig(s, 1'b1);
      cyc(5);
      check("grant while gated", {7'h00, grant.valid}, 8'h00);
      tk_q.push_back({lvl, 5'(s)});
      wr(8'ha8, (en_a == 8'ha8 ? bitv : 8'h00) | 8'h80);
      drain(0);
      if (s >= 13) rd(8'had, 8'(8'h10 << (s - 13)));
      trig(s, 1'b0);
      settle();
    end
    // Level beats order, then order breaks a tie; nothing taken meanwhile.
    take = 1'b0;
    wr(8'ha8, 8'hbf);
    wr(8'he6, 8'hf5);
    wr(8'he7, 8'hbe);
    wr(8'hf7, 8'h80);
    flags.uart_tx_done = 1'b1;
    flags.spi_irq = 1'b1;
    flags.crystal_valid_flag = 1'b1;
    cyc(2);
    check("grant", {1'b0, grant}, {2'b01, 1'b1, IMP_SRC_CRYSTAL});
    wr(8'hf7, 8'h00);
    cyc(1);
    check("grant", {1'b0, grant}, {2'b01, 1'b0, IMP_SRC_UART});
    // Low routine is preempted by high; a second high waits for the first to end.
    flags = '0;
    flags.uart_tx_done = 1'b1;
    wr(8'hf6, 8'h01);
    wr(8'hf7, 8'h80);
    tk_q.push_back({1'b0, IMP_SRC_UART});
    take = 1'b1;
    drain(0);
    flags.uart_tx_done = 1'b0;
    tk_q.push_back({1'b1, IMP_SRC_SPI});
    tk_q.push_back({1'b1, IMP_SRC_CRYSTAL});
    flags.spi_irq = 1'b1;
    flags.crystal_valid_flag = 1'b1;
    drain(1);
    check("service state", {4'h0, svc}, {4'h0, IMP_SVC_NEST});
    flags.spi_irq = 1'b0;
    drain(0);
    flags.crystal_valid_flag = 1'b0;
    settle();
    wrap_up();
  end
endmodule : testbench

`default_nettype wire

// ==== imp_pkg.sv ====
package imp_pkg;

  // Sources in fixed tie-break order; a lower code wins a tie.
  typedef enum logic [4:0] {
    IMP_SRC_PIN0     = 5'h00,
    IMP_SRC_TIMER0   = 5'h01,
    IMP_SRC_PIN1     = 5'h02,
    IMP_SRC_TIMER1   = 5'h03,
    IMP_SRC_UART     = 5'h04,
    IMP_SRC_TIMER2   = 5'h05,
    IMP_SRC_SPI      = 5'h06,
    IMP_SRC_ADC_WIN  = 5'h07,
    IMP_SRC_CMP0_F   = 5'h08,
    IMP_SRC_CMP0_R   = 5'h09,
    IMP_SRC_CMP1_F   = 5'h0a,
    IMP_SRC_CMP1_R   = 5'h0b,
    IMP_SRC_ADC_DONE = 5'h0c,
    IMP_SRC_SOFT0    = 5'h0d,
    IMP_SRC_SOFT1    = 5'h0e,
    IMP_SRC_SOFT2    = 5'h0f,
    IMP_SRC_SOFT3    = 5'h10,
    IMP_SRC_CRYSTAL  = 5'h11
  } imp_src_t;

  localparam int unsigned IMP_NUM_SRC = 18;

  // One register bus access from the core.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } imp_sfr_req_t;

  // Pending flags of the peripherals, all on the core clock.
  typedef struct packed {
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic uart_rx_done;
    logic uart_tx_done;
    logic spi_irq;
    logic adc_window;
    logic adc_done;
    logic cmp0_fall;
    logic cmp0_rise;
    logic cmp1_fall;
    logic cmp1_rise;
    logic crystal_valid_flag;
  } imp_flags_t;

  // Request presented to the core.
  typedef struct packed {
    logic     valid;
    logic     high;
    imp_src_t id;
  } imp_grant_t;

  // Service nesting state, one-hot.
  typedef enum logic [3:0] {
    IMP_SVC_IDLE = 4'h1,
    IMP_SVC_LOW  = 4'h2,
    IMP_SVC_HIGH = 4'h4,
    IMP_SVC_NEST = 4'h8
  } imp_svc_t;

endpackage : imp_pkg
